// >>> hw/psb_pkg.sv
// Overview of operation
// - A loaded write takes its first data word two enabled cycles after the load.
// - Each enabled advance cycle of a read or write burst steps the burst counter to the next burst address.
// - A new load may directly follow the fourth burst word; no idle cycle comes between.
// - Edges with clock_gate_n high are ignored and do not count toward latency.
// - Read data already on the bus stays unchanged while edges are ignored.
// - Back-to-back read loads return data every cycle, two enabled cycles after each.
// - A read loaded before a deselect still drives its data two cycles later.
// - A write loaded before a deselect still takes its data two cycles later.
// - Data outputs are high impedance as soon as reset_n goes low, with no clock edge needed.
// - Cycles with no read data or write data leave the bus high impedance.
// - Selected only with both low selects low and high select high.
// - Read-write is ignored on advance cycles; direction comes from the load.
// - Two-bit counter, linear or interleaved order, wraps after the fourth word.
package psb_pkg;

	localparam int ADDR_W  = 17;
	localparam int LANES   = 4;
	localparam int LANE_W  = 9;
	localparam int DATA_W  = LANES * LANE_W;
	localparam int BURST_W = 2;

	localparam logic [BURST_W-1:0] BURST_START = 2'h0;
	localparam logic [DATA_W-1:0]  DATA_RESET  = 36'h0_0000_0000;

	typedef enum {PSB_IDLE, PSB_READ, PSB_WRITE} psb_burst_e;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  byte_write_n;
	} psb_op_s;

	typedef struct packed {
		logic advance_or_load;
		logic read_write;
		logic select_low_a;
		logic select_low_b;
		logic select_high;
	} psb_ctrl_s;

	localparam psb_op_s OP_IDLE = '{valid: 1'b0, write: 1'b0, addr: 17'h0_0000,
		byte_write_n: 4'hF};

	function automatic logic chip_selected(input psb_ctrl_s c);
		chip_selected = !c.select_low_a && !c.select_low_b && c.select_high;
	endfunction

	// Low address bits for burst step cnt from base; linear_order_n low = linear
	function automatic logic [BURST_W-1:0] burst_addr(input logic [BURST_W-1:0] base,
		input logic [BURST_W-1:0] cnt, input logic linear_order_n);
		burst_addr = linear_order_n ? (base ^ cnt) : BURST_W'(base + cnt);
	endfunction

	// Byte lane merge; a low select writes that lane
	function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word, input logic [LANES-1:0] byte_write_n);
		logic [DATA_W-1:0] w;
		w = old_word;
		for (int i = 0; i < LANES; i++) begin
			if (!byte_write_n[i]) begin
				w[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
			end
		end
		lane_merge = w;
	endfunction

endpackage

// >>> hw/psb_mem.sv
`timescale 1ns/100ps
`default_nettype none
module psb_mem #(
	parameter int ADDR_W = psb_pkg::ADDR_W,
	parameter int LANES  = psb_pkg::LANES,
	parameter int LANE_W = psb_pkg::LANE_W
) (
	input  wire logic                      clock,
	input  wire logic                      write_en,
	input  wire logic [ADDR_W-1:0]         write_addr,
	input  wire logic [LANES*LANE_W-1:0]   write_data,
	input  wire logic [LANES-1:0]          write_byte_n,
	input  wire logic                      read_en,
	input  wire logic [ADDR_W-1:0]         read_addr,
	output logic      [LANES*LANE_W-1:0]   read_data
);

	logic [LANES*LANE_W-1:0] store [0:(1<<ADDR_W)-1];
	logic [LANES*LANE_W-1:0] read_nxt;
	logic [LANES*LANE_W-1:0] word_nxt;

	// Write-first: a read on the edge that writes the same word sees the new lanes,
	// so a read loaded right behind a write gets no stale data
	always_comb begin
		word_nxt = psb_pkg::lane_merge(store[write_addr], write_data, write_byte_n);
		read_nxt = read_data;
		if (read_en) begin
			read_nxt = store[read_addr];
			if (write_en && (write_addr == read_addr)) begin
				read_nxt = word_nxt;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (write_en) begin
			store[write_addr] <= word_nxt;
		end
		read_data <= read_nxt;
	end

endmodule
`default_nettype wire

// >>> hw/psb_burst.sv
`timescale 1ns/100ps
`default_nettype none
module psb_burst #(
	parameter int BURST_W = psb_pkg::BURST_W
) (
	input  wire logic               clock,
	input  wire logic               reset_n,
	input  wire logic               enable,
	input  wire logic               load,
	input  wire logic               advance,
	input  wire logic [BURST_W-1:0] load_low,
	input  wire logic               linear_order_n,
	output logic      [BURST_W-1:0] addr_low
);

	logic [BURST_W-1:0] base_r;
	logic [BURST_W-1:0] base_nxt;
	logic [BURST_W-1:0] cnt_r;
	logic [BURST_W-1:0] cnt_nxt;

	always_comb begin
		base_nxt = base_r;
		cnt_nxt  = cnt_r;
		if (enable && load) begin
			base_nxt = load_low;
			cnt_nxt  = psb_pkg::BURST_START;
		end else if (enable && advance) begin
			cnt_nxt = BURST_W'(cnt_r + 1'b1);
		end
		addr_low = load ? load_low : psb_pkg::burst_addr(base_r, cnt_nxt, linear_order_n);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			base_r <= psb_pkg::BURST_START;
			cnt_r  <= psb_pkg::BURST_START;
		end else begin
			base_r <= base_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	a_burst_step: assert property (@(posedge clock) disable iff (!reset_n)
		enable && advance && !load |=> cnt_r == BURST_W'($past(cnt_r) + 1'b1))
		else $error("burst counter did not step on an advance");

	a_burst_wrap: assert property (@(posedge clock) disable iff (!reset_n)
		(enable && load) ##1 (enable && advance && !load) [*4] |=> cnt_r == psb_pkg::BURST_START)
		else $error("burst counter did not wrap after four advances");

endmodule
`default_nettype wire

// >>> hw/psb_sram.sv
`timescale 1ns/100ps
`default_nettype none
module psb_sram #(
	parameter int ADDR_W = psb_pkg::ADDR_W,
	parameter int LANES  = psb_pkg::LANES,
	parameter int LANE_W = psb_pkg::LANE_W
) (
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	input  wire logic [ADDR_W-1:0]       address,
	input  wire logic                    read_write,
	input  wire logic                    advance_or_load,
	input  wire logic                    select_low_a,
	input  wire logic                    select_low_b,
	input  wire logic                    select_high,
	input  wire logic                    clock_gate_n,
	input  wire logic [LANES-1:0]        byte_write_n,
	input  wire logic                    linear_order_n,
	input  wire logic                    output_drive_n,
	input  wire logic [LANES*LANE_W-1:0] data_in,
	output logic      [LANES*LANE_W-1:0] data_out,
	output logic      [LANES*LANE_W-1:0] data_oe
);

	localparam int DATA_W  = LANES * LANE_W;
	localparam int BURST_W = psb_pkg::BURST_W;

	psb_pkg::psb_ctrl_s  ctrl;
	logic                enable;
	logic                load;
	logic                selected;
	logic                burst_go;
	logic [BURST_W-1:0]  addr_low;

	psb_pkg::psb_burst_e burst_r;
	psb_pkg::psb_burst_e burst_nxt;
	logic [ADDR_W-1:0]   burst_base_r;
	logic [ADDR_W-1:0]   burst_base_nxt;

	psb_pkg::psb_op_s    op_now;
	psb_pkg::psb_op_s    stage1_r;
	psb_pkg::psb_op_s    stage1_nxt;
	psb_pkg::psb_op_s    stage2_r;
	psb_pkg::psb_op_s    stage2_nxt;

	logic                mem_we;
	logic                mem_re;
	logic [DATA_W-1:0]   mem_rdata;

	logic [DATA_W-1:0]   data_out_r;
	logic [DATA_W-1:0]   data_out_nxt;
	logic                rd_drive_r;
	logic                rd_drive_nxt;

	// The far end runs on this same clock, so its pins are sampled directly
	assign ctrl = '{advance_or_load: advance_or_load, read_write: read_write,
		select_low_a: select_low_a, select_low_b: select_low_b, select_high: select_high};

	assign enable   = !clock_gate_n;
	assign load     = !ctrl.advance_or_load;
	assign selected = psb_pkg::chip_selected(ctrl);
	assign burst_go = !load && (burst_r != psb_pkg::PSB_IDLE);

	psb_burst #(
		.BURST_W (BURST_W)
	) u_burst (
		.clock          (clock),
		.reset_n        (reset_n),
		.enable         (enable),
		.load           (load && selected),
		.advance        (burst_go),
		.load_low       (address[BURST_W-1:0]),
		.linear_order_n (linear_order_n),
		.addr_low       (addr_low)
	);

	// Burst direction and base address, fixed at the load
	always_comb begin
		burst_nxt      = burst_r;
		burst_base_nxt = burst_base_r;
		if (enable && load) begin
			if (selected) begin
				burst_nxt      = ctrl.read_write ? psb_pkg::PSB_READ : psb_pkg::PSB_WRITE;
				burst_base_nxt = address;
			end else begin
				burst_nxt = psb_pkg::PSB_IDLE;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			burst_r      <= psb_pkg::PSB_IDLE;
			burst_base_r <= '0;
		end else begin
			burst_r      <= burst_nxt;
			burst_base_r <= burst_base_nxt;
		end
	end

	// Operation issued this cycle; read_write is not looked at while advancing
	always_comb begin
		op_now = psb_pkg::OP_IDLE;
		op_now.byte_write_n = byte_write_n;
		if (load) begin
			op_now.valid = selected;
			op_now.write = !ctrl.read_write;
			op_now.addr  = address;
		end else begin
			op_now.valid = burst_go;
			op_now.write = (burst_r == psb_pkg::PSB_WRITE);
			op_now.addr  = {burst_base_r[ADDR_W-1:BURST_W], addr_low};
		end
	end

	// Two-stage pipeline; a gated edge freezes every stage
	always_comb begin
		stage1_nxt = stage1_r;
		stage2_nxt = stage2_r;
		if (enable) begin
			stage1_nxt = op_now;
			stage2_nxt = stage1_r;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stage1_r <= psb_pkg::OP_IDLE;
			stage2_r <= psb_pkg::OP_IDLE;
		end else begin
			stage1_r <= stage1_nxt;
			stage2_r <= stage2_nxt;
		end
	end

	// Write data lands on the second enabled edge, whatever the selects do then
	assign mem_we = enable && stage2_r.valid && stage2_r.write;
	// Reads fetch one edge early so data_out can come from a flop at the data phase
	assign mem_re = enable && stage1_r.valid && !stage1_r.write;

	psb_mem #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES),
		.LANE_W (LANE_W)
	) u_mem (
		.clock        (clock),
		.write_en     (mem_we),
		.write_addr   (stage2_r.addr),
		.write_data   (data_in),
		.write_byte_n (stage2_r.byte_write_n),
		.read_en      (mem_re),
		.read_addr    (stage1_r.addr),
		.read_data    (mem_rdata)
	);

	always_comb begin
		data_out_nxt = data_out_r;
		rd_drive_nxt = rd_drive_r;
		if (enable) begin
			rd_drive_nxt = stage2_r.valid && !stage2_r.write;
			if (rd_drive_nxt) begin
				data_out_nxt = mem_rdata;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			data_out_r <= psb_pkg::DATA_RESET;
			rd_drive_r <= 1'b0;
		end else begin
			data_out_r <= data_out_nxt;
			rd_drive_r <= rd_drive_nxt;
		end
	end

	assign data_out = data_out_r;
	// The drive gate stays asynchronous so the controller can release the bus at once
	assign data_oe  = {DATA_W{rd_drive_r && !output_drive_n}};

	sequence s_read_load;
		enable && load && selected && ctrl.read_write;
	endsequence

	sequence s_write_load;
		enable && load && selected && !ctrl.read_write;
	endsequence

	sequence s_two_enabled;
		enable ##1 enable;
	endsequence

	sequence s_advance;
		enable && burst_go;
	endsequence

	sequence s_deselect;
		enable && load && !selected;
	endsequence

	a_write_commit: assert property (@(posedge clock) disable iff (!reset_n)
		s_write_load ##1 s_two_enabled |-> mem_we && (stage2_r.addr == $past(address, 2)))
		else $error("loaded write not committed two enabled cycles later");

	a_write_deselect: assert property (@(posedge clock) disable iff (!reset_n)
		s_write_load ##1 (enable && !selected) ##1 (enable && !selected) |-> mem_we)
		else $error("write lost after deselect");

	a_gate_freeze: assert property (@(posedge clock) disable iff (!reset_n)
		!enable |=> $stable(stage1_r) && $stable(stage2_r) && $stable(burst_r))
		else $error("pipeline moved on a gated edge");

	a_read_hold: assert property (@(posedge clock) disable iff (!reset_n)
		rd_drive_r && !enable |=> rd_drive_r && $stable(data_out_r))
		else $error("read data changed while edges were gated");

	a_read_back: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_load ##1 s_read_load ##1 enable |=> rd_drive_r ##1 (!enable || rd_drive_r))
		else $error("back-to-back reads left a dead cycle");

	a_read_deselect: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_load ##1 (enable && load && !selected) ##1 enable |=> rd_drive_r)
		else $error("read lost after deselect");

	a_deselect_hiz: assert property (@(posedge clock) disable iff (!reset_n)
		(enable && load && !selected) ##1 s_two_enabled |=> !rd_drive_r)
		else $error("bus driven two cycles after deselect");

	a_idle_hiz: assert property (@(posedge clock) disable iff (!reset_n)
		enable && !stage2_r.valid |=> !rd_drive_r && data_oe == '0)
		else $error("bus driven with no read in the data phase");

	a_dir_fixed: assert property (@(posedge clock) disable iff (!reset_n)
		enable && burst_go |=> stage1_r.write == $past(stage1_r.write))
		else $error("burst direction followed read_write");

	a_new_load: assert property (@(posedge clock) disable iff (!reset_n)
		enable && load && selected |=> stage1_r.valid && stage1_r.addr == $past(address))
		else $error("load not taken into the pipeline");

	a_drive_gate: assert property (@(posedge clock) disable iff (!reset_n)
		output_drive_n |-> data_oe == '0)
		else $error("bus driven while output_drive_n high");

	a_select_decode: assert property (@(posedge clock) disable iff (!reset_n)
		enable && load && (select_low_a || select_low_b || !select_high) |=> !stage1_r.valid)
		else $error("deselect issued an operation");

	a_read_latency: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_load ##1 s_two_enabled |=> rd_drive_r)
		else $error("read data not driven two enabled cycles after its load");

	a_read_gated: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_load ##1 !enable ##1 s_two_enabled |=> rd_drive_r)
		else $error("gated edge broke the read latency");

	a_write_gated: assert property (@(posedge clock) disable iff (!reset_n)
		s_write_load ##1 !enable ##1 s_two_enabled
			|-> mem_we && stage2_r.addr == $past(address, 3))
		else $error("gated edge broke the write latency");

	a_burst_upper: assert property (@(posedge clock) disable iff (!reset_n)
		s_advance |=> stage1_r.valid
			&& stage1_r.addr[ADDR_W-1:BURST_W] == $past(stage1_r.addr[ADDR_W-1:BURST_W]))
		else $error("burst advance lost the upper address bits");

	a_linear_step: assert property (@(posedge clock) disable iff (!reset_n)
		enable && burst_go && !linear_order_n |=> stage1_r.addr[BURST_W-1:0]
			== BURST_W'($past(stage1_r.addr[BURST_W-1:0]) + 1'b1))
		else $error("linear burst did not step by one word");

	a_deselect_stop: assert property (@(posedge clock) disable iff (!reset_n)
		s_deselect |=> burst_r == psb_pkg::PSB_IDLE)
		else $error("deselect did not end the burst");

	a_noop_idle: assert property (@(posedge clock) disable iff (!reset_n)
		enable && !load && burst_r == psb_pkg::PSB_IDLE |=> !stage1_r.valid)
		else $error("advance with no burst issued an operation");

	a_write_quiet: assert property (@(posedge clock) disable iff (!reset_n)
		enable && stage2_r.valid && stage2_r.write |=> !rd_drive_r)
		else $error("bus driven in a write data phase");

	a_fetch_freeze: assert property (@(posedge clock) disable iff (!reset_n)
		!enable |=> $stable(mem_rdata))
		else $error("memory read moved on a gated edge");

	a_load_dir: assert property (@(posedge clock) disable iff (!reset_n)
		enable && load && selected |=> stage1_r.write == !$past(read_write))
		else $error("load direction not taken from read_write");

	a_stage_shift: assert property (@(posedge clock) disable iff (!reset_n)
		enable |=> stage2_r == $past(stage1_r))
		else $error("pipeline skipped a stage");

	a_burst_hold: assert property (@(posedge clock) disable iff (!reset_n)
		s_advance |=> burst_r == $past(burst_r))
		else $error("burst direction changed on an advance");

	a_chain_write: assert property (@(posedge clock) disable iff (!reset_n)
		s_write_load ##1 (enable && burst_go) [*3] ##1 s_write_load ##1 s_two_enabled
			|-> mem_we && stage2_r.addr == $past(address, 2))
		else $error("chained write load lost its data phase");

	a_chain_read: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_load ##1 (enable && burst_go) [*3] ##1 s_read_load ##1 s_two_enabled
			|-> rd_drive_r ##1 rd_drive_r)
		else $error("chained read load left an idle cycle");

	a_oe_follow: assert property (@(posedge clock) disable iff (!reset_n)
		rd_drive_r && !output_drive_n |-> data_oe == '1)
		else $error("read data not driven with output_drive_n low");

endmodule
`default_nettype wire

// >>> dv/psb_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module psb_ctrl_model (
	input  wire logic              clock,
	output var psb_pkg::psb_ctrl_s ctl,
	output var logic [16:0]        address,
	output var logic               clock_gate_n,
	output var logic [3:0]         byte_write_n,
	output var logic               linear_order_n,
	output var logic               output_drive_n,
	output var logic [35:0]        data_in
);
	logic [36:0] cur;
	logic [36:0] p1;
	logic [36:0] p2;

	initial begin
		ctl = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		address = 17'h0_0000;
		clock_gate_n = 1'b0;
		byte_write_n = 4'hF;
		linear_order_n = 1'b0;
		output_drive_n = 1'b0;
		data_in = 36'h0_0000_0000;
		cur = '0;
		p1 = '0;
		p2 = '0;
	end

	// Released bus flips every cycle so stale data never matches by chance
	always @(posedge clock) begin
		if (!clock_gate_n) begin
			p2 <= p1;
			p1 <= cur;
			data_in <= p1[36] ? p1[35:0] : ~data_in;
		end else if (!p2[36]) begin
			data_in <= ~data_in;
		end
	end

	task automatic drive(input psb_pkg::psb_ctrl_s c, input logic [16:0] a, input logic g,
		input logic [3:0] bw, input logic wv, input logic [35:0] wd, input logic lon,
		input logic odn);
		ctl = c;
		address = a;
		clock_gate_n = g;
		byte_write_n = bw;
		cur = {wv, wd};
		linear_order_n = lon;
		output_drive_n = odn;
	endtask
endmodule
`default_nettype wire

// >>> dv/pipelined_sram_bus_cycles_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pipelined_sram_bus_cycles_tb;
	typedef struct packed {
		logic        drive;
		logic [35:0] data;
	} psb_note_s;

	logic               clock;
	logic               reset_n;
	logic               clock_gate_n;
	logic               linear_order_n;
	logic               output_drive_n;
	logic               b_on;
	logic               b_w;
	logic               b_lon;
	logic               seen_drv;
	logic               g;
	logic [16:0]        address;
	logic [16:0]        b_a;
	logic [1:0]         b_k;
	logic [3:0]         byte_write_n;
	logic [35:0]        data_in;
	logic [35:0]        data_out;
	logic [35:0]        data_oe;
	logic [35:0]        last_out;
	logic [35:0]        mem [0:63];
	logic [2:0]         dsel [0:2];
	psb_pkg::psb_ctrl_s ctl;
	psb_note_s          exp_q [$];
	psb_note_s          nt;
	int                 fails;
	int                 samples_checked;
	int                 r;

	psb_ctrl_model psb_ctrl_model_i (
		.clock(clock), .ctl(ctl), .address(address), .clock_gate_n(clock_gate_n),
		.byte_write_n(byte_write_n), .linear_order_n(linear_order_n),
		.output_drive_n(output_drive_n), .data_in(data_in)
	);

	psb_sram psb_sram_i (
		.clock(clock), .reset_n(reset_n), .address(address),
		.read_write(ctl.read_write), .advance_or_load(ctl.advance_or_load),
		.select_low_a(ctl.select_low_a), .select_low_b(ctl.select_low_b),
		.select_high(ctl.select_high), .clock_gate_n(clock_gate_n),
		.byte_write_n(byte_write_n), .linear_order_n(linear_order_n),
		.output_drive_n(output_drive_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe)
	);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic close_out();
		if (fails == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Reference memory is updated when each write word issues, at load or advance: a later read sees it
	task automatic op(input logic ld, input logic rw, input logic [2:0] s,
		input logic [16:0] a, input logic gt, input logic [3:0] bw, input logic lon,
		input logic odn);
		psb_pkg::psb_ctrl_s c;
		logic [35:0]        wd;
		logic [16:0]        ea;
		@(posedge clock);
		#2;
		wd = {4'($urandom), $urandom};
		c = '{!ld, rw, s[2], s[1], s[0]};
		if (!gt) begin
			if (ld) begin
				b_on = (s == 3'b001);
				b_w = !rw;
				b_a = a;
				b_k = 2'h0;
				b_lon = lon;
			end else begin
				b_k = b_k + 2'h1;
			end
			ea = {b_a[16:2], b_lon ? b_a[1:0] ^ b_k : b_a[1:0] + b_k};
			if (b_on && b_w) begin
				for (int i = 0; i < 4; i++) begin
					if (!bw[i]) begin
						mem[ea[5:0]][i*9 +: 9] = wd[i*9 +: 9];
					end
				end
			end
			exp_q.push_back('{b_on && !b_w, (b_on && !b_w) ? mem[ea[5:0]] : 36'h0});
		end
		psb_ctrl_model_i.drive(c, a, gt, bw, b_on && b_w, wd, ld ? lon : b_lon, odn);
	endtask

	always begin
		@(posedge clock);
		g = clock_gate_n;
		#1;
		if (!reset_n) begin
			seen_drv = 1'b0;
			last_out = 36'h0_0000_0000;
			chk(data_oe, 36'h0_0000_0000);
		end else if (g) begin
			chk(data_out, last_out);
			chk(data_oe, {36{seen_drv & !output_drive_n}});
		end else if (exp_q.size() == 3) begin
			nt = exp_q.pop_front();
			seen_drv = nt.drive;
			if (nt.drive) begin
				chk(data_out, nt.data);
			end
			chk(data_oe, {36{nt.drive & !output_drive_n}});
			if (nt.drive) begin
				last_out = nt.data;
			end
		end
	end

	initial begin
		#(40 * 2000);
		fails++;
		close_out();
	end

	initial begin
		void'($urandom(73906));
		reset_n = 1'b0;
		fails = 0;
		samples_checked = 0;
		b_on = 1'b0;
		b_w = 1'b0;
		b_lon = 1'b0;
		b_a = 17'h0_0000;
		b_k = 2'h0;
		dsel = '{3'b101, 3'b011, 3'b000};
		exp_q.push_back('0);
		exp_q.push_back('0);
		repeat (8) @(posedge clock);
		#2;
		reset_n = 1'b1;
		// Chained four-word bursts, every start offset in both orders
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 16; i++) begin
				for (int k = 0; k < 4; k++) begin
					op(k == 0, k == 0 ? p[0] : 1'($urandom), 3'b001,
						17'({i[3:0], i[1:0]}), 1'b0, 4'h0, i[2], 1'b0);
				end
			end
		end
		for (int j = 0; j < 400; j++) begin
			r = $urandom % 8;
			op(r < 4 || r == 5, r[0], r == 5 ? dsel[$urandom % 3] : 3'b001,
				17'($urandom % 64), r == 6, 4'($urandom), 1'($urandom),
				$urandom % 8 == 0);
		end
		repeat (3) op(1'b1, 1'b1, 3'b101, 17'h0_0000, 1'b0, 4'hF, 1'b0, 1'b0);
		@(posedge clock);
		#2;
		close_out();
	end
endmodule
`default_nettype wire
